// ===== dv/temp_master_bus_cycle_release_tb.sv
// Testbench: temporary-master bus cycles against the bus-side model
`timescale 1ns/1ps
module temp_master_bus_cycle_release_tb;
  import tmb_pkg::*;

  logic clock = 1'b0, busClk = 1'b0, reset_n = 1'b0;
  logic localStrobe = 1'b0, localMemCycle = 1'b0, localIoCycle = 1'b0;
  logic localIntAck = 1'b0, localIsRead = 1'b0, localIsFetch = 1'b0;
  logic [15:0] localAddr = 16'h0000, extAddrHigh = 16'hA5A5;
  logic [7:0]  localWrData = 8'h00, rdByte = 8'h00, localRdData;
  logic [7:0]  busDataIn, busDataOut, strobeLen, lastWr;
  logic [3:0]  waits = 4'h0;
  logic useX = 1'b0, localReady, busRdy, busXrdy, busHlda, busHold_n;
  logic arbitrationWinner, holdOut, holdOe, arbEnable, pSync, pStval_n;
  logic pDbin, pWr_n, controlOe, cpuBusDisable_n, cpuCommandDisable_n;
  logic addrStatusDataOe, rdSeen, wrSeen, orderBad;
  logic [23:0] busAddr, lastAddr;
  tmb_status_t busStatus, lastStatus;
  int n_mismatch = 0, n_checks = 0;

  always #20 clock = ~clock;
  always #6 busClk = ~busClk;

  tmb_bus_cycle DUT (.clock(clock), .reset_n(reset_n), .busClk(busClk),
    .localStrobe(localStrobe), .localMemCycle(localMemCycle),
    .localIoCycle(localIoCycle), .localIntAck(localIntAck),
    .localIsRead(localIsRead), .localIsFetch(localIsFetch),
    .localAddr(localAddr), .localWrData(localWrData),
    .extAddrHigh(extAddrHigh), .localReady(localReady),
    .localRdData(localRdData), .busRdy(busRdy), .busXrdy(busXrdy),
    .busHlda(busHlda), .busHold_n(busHold_n),
    .arbitrationWinner(arbitrationWinner), .busDataIn(busDataIn),
    .holdOut(holdOut), .holdOe(holdOe), .arbEnable(arbEnable),
    .pSync(pSync), .pStval_n(pStval_n), .pDbin(pDbin), .pWr_n(pWr_n),
    .controlOe(controlOe), .cpuBusDisable_n(cpuBusDisable_n),
    .cpuCommandDisable_n(cpuCommandDisable_n),
    .addrStatusDataOe(addrStatusDataOe), .busAddr(busAddr),
    .busStatus(busStatus), .busDataOut(busDataOut));

  tmb_bus_partner model (.busClk(busClk), .reset_n(reset_n),
    .waits(waits), .useX(useX), .rdByte(rdByte), .holdOe(holdOe),
    .arbEnable(arbEnable), .pSync(pSync), .pStval_n(pStval_n),
    .pDbin(pDbin), .pWr_n(pWr_n), .controlOe(controlOe),
    .cpuBusDisable_n(cpuBusDisable_n),
    .cpuCommandDisable_n(cpuCommandDisable_n),
    .addrStatusDataOe(addrStatusDataOe), .busAddr(busAddr),
    .busStatus(busStatus), .busDataOut(busDataOut),
    .busHold_n(busHold_n), .busHlda(busHlda),
    .arbitrationWinner(arbitrationWinner), .busRdy(busRdy),
    .busXrdy(busXrdy), .busDataIn(busDataIn), .strobeLen(strobeLen),
    .rdSeen(rdSeen), .wrSeen(wrSeen), .lastAddr(lastAddr),
    .lastStatus(lastStatus), .lastWr(lastWr), .orderBad(orderBad));

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // Every bus driver idle, as after reset or a finished cycle
  task automatic check_idle();
    check({holdOe, arbEnable, controlOe, addrStatusDataOe}, 4'h0);
    check({pSync, pDbin, pWr_n, pStval_n}, 4'h3);
    check({holdOut, cpuBusDisable_n, cpuCommandDisable_n}, 3'h3);
  endtask : check_idle
  // Start a local cycle; the status leads the strobe by one clock
  task automatic start(input logic mem, input logic rd,
                       input logic [15:0] a, input logic [7:0] wd,
                       input logic [7:0] rb, input logic [3:0] w,
                       input logic x);
    @(posedge clock);
    waits <= w; useX <= x; rdByte <= rb; localWrData <= wd;
    localMemCycle <= mem; localIoCycle <= !mem; localIsRead <= rd;
    localAddr <= a;
    @(posedge clock);
    localStrobe <= 1'b1;
  endtask : start

  task automatic finish_local();
    @(posedge clock);
    localStrobe <= 1'b0; localMemCycle <= 1'b0; localIoCycle <= 1'b0;
    localIntAck <= 1'b0;
    @(posedge clock);
  endtask : finish_local

  // Full external cycle, judged at the bus and at the local side
  task automatic ext_cycle(input logic mem, input logic rd,
                           input logic [15:0] a, input logic [7:0] d,
                           input logic [3:0] w, input logic x,
                           input logic [4:0] st);
    int i;
    start(mem, rd, a, rd ? ~d : d, d, w, x);
    @(posedge clock); #1;
    check(localReady, 1'b0);
    for (i = 0; i < 500 && localReady !== 1'b1; i++) @(posedge clock);
    if (localReady !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end
    @(posedge clock); #1;
    check_idle();
    check(orderBad, 1'b0);
    check(strobeLen >= 8'(w) + 8'h01, 1'b1);
    check({rdSeen, wrSeen}, {rd, !rd});
    check(lastAddr, {extAddrHigh, a[7:0]});
    check(lastStatus, st);
    if (rd) check(localRdData, d);
    else check(lastWr, d);
    finish_local();
  endtask : ext_cycle

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic sc_memory_read();
    localIsFetch <= 1'b1;
    ext_cycle(1'b1, 1'b1, 16'hC012, 8'h3C, 4'h0, 1'b0, 5'h13);
    localIsFetch <= 1'b0;
  endtask : sc_memory_read

  // Back to back: slow write on XRDY, slow write on RDY, then slow read on XRDY
  task automatic sc_slow_writes();
    extAddrHigh <= 16'h0F1E;
    ext_cycle(1'b0, 1'b0, 16'h0077, 8'hC3, 4'h2, 1'b1, 5'h04);
    ext_cycle(1'b1, 1'b0, 16'hFFFE, 8'h96, 4'h3, 1'b0, 5'h00);
    ext_cycle(1'b0, 1'b1, 16'h00A0, 8'h5E, 4'h1, 1'b1, 5'h09);
  endtask : sc_slow_writes

  // Local memory and interrupt acknowledge never reach the bus
  task automatic sc_local_only();
    start(1'b1, 1'b1, 16'h4000, 8'h00, 8'h00, 4'h0, 1'b0);
    repeat (2) @(posedge clock);
    #1 check({localReady, holdOe, controlOe}, 3'h4);
    finish_local();
    localIntAck <= 1'b1;
    start(1'b0, 1'b1, 16'h0010, 8'h00, 8'h00, 4'h0, 1'b0);
    repeat (2) @(posedge clock);
    #1 check({localReady, holdOe, controlOe}, 3'h4);
    finish_local();
  endtask : sc_local_only

  // Reset in the middle of a long wait-stretched cycle
  task automatic sc_mid_reset();
    start(1'b1, 1'b1, 16'hC100, 8'h11, 8'h11, 4'hF, 1'b0);
    repeat (6) @(posedge clock);
    reset_n <= 1'b0;
    repeat (5) @(posedge clock);
    #1 check_idle();
    finish_local();
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    ext_cycle(1'b1, 1'b1, 16'hC0FF, 8'hA9, 4'h0, 1'b0, 5'h11);
  endtask : sc_mid_reset
  // Watchdog on the whole run
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    #1 check_idle();
    check(localReady, 1'b1);
    sc_memory_read();
    sc_slow_writes();
    sc_local_only();
    sc_mid_reset();
    tally_and_finish();
  end
endmodule : temp_master_bus_cycle_release_tb

// ===== dv/tmb_bus_partner.sv
// Bus-side model: permanent master hold handshake, slow slave and monitor
`timescale 1ns/1ps
module tmb_bus_partner
  import tmb_pkg::*;
(
  input  wire logic                       busClk,
  input  wire logic                       reset_n,
  input  wire logic [3:0]                 waits,
  input  wire logic                       useX,
  input  wire logic [tmb_pkg::DATA_W-1:0] rdByte,
  input  wire logic                       holdOe,
  input  wire logic                       arbEnable,
  input  wire logic                       pSync,
  input  wire logic                       pStval_n,
  input  wire logic                       pDbin,
  input  wire logic                       pWr_n,
  input  wire logic                       controlOe,
  input  wire logic                       cpuBusDisable_n,
  input  wire logic                       cpuCommandDisable_n,
  input  wire logic                       addrStatusDataOe,
  input  wire logic [23:0]                busAddr,
  input  wire tmb_pkg::tmb_status_t       busStatus,
  input  wire logic [tmb_pkg::DATA_W-1:0] busDataOut,
  output      logic                       busHold_n,
  output      logic                       busHlda,
  output      logic                       arbitrationWinner,
  output      logic                       busRdy,
  output      logic                       busXrdy,
  output      logic [tmb_pkg::DATA_W-1:0] busDataIn,
  output      logic [7:0]                 strobeLen,
  output      logic                       rdSeen,
  output      logic                       wrSeen,
  output      logic [23:0]                lastAddr,
  output      tmb_pkg::tmb_status_t       lastStatus,
  output      logic [tmb_pkg::DATA_W-1:0] lastWr,
  output      logic                       orderBad
);
  import tmb_pkg::*;

  logic       holdSeen_q;
  logic [3:0] waitCnt_q;
  logic [7:0] junk_q;
  logic       strobe;
  logic       asdOe_q;

  // Open-collector HOLD line with pull-up; sole contender always wins
  assign busHold_n         = !holdOe;
  assign arbitrationWinner = arbEnable;
  assign strobe            = pDbin || !pWr_n;

  // Bus CPU grants one T-state after it sees HOLD, drops with HOLD
  always_ff @(posedge busClk) begin
    holdSeen_q <= reset_n && !busHold_n;
    busHlda    <= reset_n && holdSeen_q && !busHold_n;
  end

  // slave stretches strobe; ready low early since sampling lags
  always_ff @(posedge busClk) begin
    if (!controlOe) begin
      waitCnt_q <= waits;
    end else if (strobe && waitCnt_q != 4'h0) begin
      waitCnt_q <= waitCnt_q - 4'h1;
    end
  end
  assign busRdy  = !(waitCnt_q != 4'h0 && !useX);
  assign busXrdy = !(waitCnt_q != 4'h0 && useX);

  // Undriven data lines wander each cycle, so stale data cannot pass
  always_ff @(posedge busClk) begin
    junk_q <= reset_n ? ~junk_q ^ 8'h01 : 8'h5A;
  end
  assign busDataIn = pDbin ? rdByte : junk_q;

  always_ff @(posedge busClk) begin
    asdOe_q <= addrStatusDataOe;
    if (!reset_n) begin
      strobeLen <= 8'h00;
      rdSeen    <= 1'b0;
      wrSeen    <= 1'b0;
      orderBad  <= 1'b0;
    end else if (pSync) begin
      strobeLen  <= 8'h00;
      rdSeen     <= 1'b0;
      wrSeen     <= 1'b0;
      lastAddr   <= busAddr;
      lastStatus <= busStatus;
    end else if (strobe) begin
      strobeLen <= strobeLen + 8'h01;
      rdSeen    <= rdSeen | pDbin;
      wrSeen    <= wrSeen | !pWr_n;
      lastWr    <= busDataOut;
    end
    if (reset_n && ((asdOe_q && !addrStatusDataOe && !controlOe) ||
        (addrStatusDataOe && !controlOe) || (pSync && strobe) ||
        (addrStatusDataOe === cpuCommandDisable_n) ||
        (controlOe === cpuBusDisable_n) || (pSync === pStval_n))) begin
      orderBad <= 1'b1;
    end
  end
endmodule : tmb_bus_partner

// ===== hdl/tmb_bus_cycle.sv
// Temporary-master bus cycle sequencer: strobe, hold time and bus hand-back
// Function
// - First-T-state rising edge sets strobe window, ends sync, enables strobe.
// - Strobe drives read strobe or write strobe by stalled local cycle type.
// - Ready lines sampled at that edge; either low adds a strobe wait.
// - Strobe state begun with both ready high sets strobe stop flag.
// - Next bus clock after strobe stop clears the external cycle flag.
// - Cycle low with window set pulses release, clearing pending and assert on the same edge.
// - Cycle low drops address, status, data drivers; control still driven.
// - Next falling edge with assert low clears control drive flag.
// - Following rising edge, cycle low clears the strobe window flag.
// - Falling strobe window sets wait release, freeing the local processor.
// - Read data latched by strobe end, presented on internal data bus.
// - One more clock with window low clears stop; all back to idle.
// - Falling edge after hold acknowledge, when winner, sets control drive.
// - Next rising edge sets cycle flag, drivers on, command disable asserted.
// - Sync high for first T-state; status valid low in its second half.
// - External access decode deasserts local processor ready until done.
`timescale 1ns/1ps
module tmb_bus_cycle
  import tmb_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        reset_n,
  input  wire logic                        busClk,
  input  wire logic                        localStrobe,
  input  wire logic                        localMemCycle,
  input  wire logic                        localIoCycle,
  input  wire logic                        localIntAck,
  input  wire logic                        localIsRead,
  input  wire logic                        localIsFetch,
  input  wire logic [15:0]                 localAddr,
  input  wire logic [tmb_pkg::DATA_W-1:0]  localWrData,
  input  wire logic [tmb_pkg::ADDR_HIGH_W-1:0] extAddrHigh,
  output      logic                        localReady,
  output      logic [tmb_pkg::DATA_W-1:0]  localRdData,
  input  wire logic                        busRdy,
  input  wire logic                        busXrdy,
  input  wire logic                        busHlda,
  input  wire logic                        busHold_n,
  input  wire logic                        arbitrationWinner,
  input  wire logic [tmb_pkg::DATA_W-1:0]  busDataIn,
  output      logic                        holdOut,
  output      logic                        holdOe,
  output      logic                        arbEnable,
  output      logic                        pSync,
  output      logic                        pStval_n,
  output      logic                        pDbin,
  output      logic                        pWr_n,
  output      logic                        controlOe,
  output      logic                        cpuBusDisable_n,
  output      logic                        cpuCommandDisable_n,
  output      logic                        addrStatusDataOe,
  output      logic [23:0]                 busAddr,
  output      tmb_pkg::tmb_status_t        busStatus,
  output      logic [tmb_pkg::DATA_W-1:0]  busDataOut
);
  import tmb_pkg::*;

  // ***************************************************************
  // Local processor domain
  // ***************************************************************
  tmb_loc_state_t locState_q;
  tmb_req_t       req_q;
  logic           reqTgl_q;
  logic           endTglSync;
  logic           endTglSeen_q;
  logic           externalAccessDecode;

  // Memory at or above the window base, or any port access except acknowledge
  function automatic logic isExternal(input logic mem, input logic io,
                                      input logic ack, input logic [15:0] a);
    isExternal = (mem && (a[15 -: EXT_MEM_TOP_BITS] ==
                  EXT_MEM_BASE[15 -: EXT_MEM_TOP_BITS])) || (io && !ack);
  endfunction : isExternal

  assign externalAccessDecode = isExternal(localMemCycle, localIoCycle,
                                           localIntAck, localAddr);

  assign localReady = !externalAccessDecode || (locState_q == LOC_DONE);

  // Request is launched on the strobe and held until the processor moves on
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      locState_q <= LOC_IDLE;
      reqTgl_q   <= FLAG_RESET;
      req_q      <= '0;
    end else begin
      case (locState_q)
        LOC_IDLE: begin
          if (externalAccessDecode && localStrobe) begin
            req_q      <= '{localIoCycle, localIsRead, localIsFetch,
                            localAddr[ADDR_LOW_W-1:0], localWrData};
            reqTgl_q   <= !reqTgl_q;
            locState_q <= LOC_WAIT;
          end
        end
        LOC_WAIT: begin
          if (endTglSync != endTglSeen_q) begin
            locState_q <= LOC_DONE;
          end
        end
        LOC_DONE: begin
          if (!localStrobe) begin
            locState_q <= LOC_IDLE;
          end
        end
        default: locState_q <= LOC_IDLE;
      endcase
    end
  end

  // wait release seen locally; read data taken across
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      endTglSeen_q <= FLAG_RESET;
      localRdData  <= '0;
    end else if (endTglSync != endTglSeen_q) begin
      endTglSeen_q <= endTglSync;
      localRdData  <= busDataOut;    // Held stable since the strobe ended
    end
  end

  // ***************************************************************
  // Crossings
  // ***************************************************************
  logic [BUS_PIN_W-1:0] pinSync;
  logic                 busRstSync_n;
  logic                 reqTglSync;
  logic                 endTgl_q;

  tmb_sync #(.WIDTH(BUS_PIN_W + 2)) u_busSync (
    .clk  (busClk),
    .din  ({arbitrationWinner, !busHold_n, busHlda, busXrdy, busRdy,
            reset_n, reqTgl_q}),
    .dout ({pinSync, busRstSync_n, reqTglSync})
  );

  tmb_sync #(.WIDTH(1)) u_locSync (
    .clk  (clock),
    .din  (endTgl_q),
    .dout (endTglSync)
  );

  // ***************************************************************
  // Bus clock domain, rising edge
  // ***************************************************************
  logic reqTglSeen_q;
  logic requestPendingFlag;
  logic arbitrationAssertFlag;
  logic controlDriveFlag;
  logic externalCycleFlag;
  logic strobeWindowFlag;
  logic strobeStopFlag;
  logic readyOk_q;
  logic handBackPulse;
  logic bothReady;
  logic strobeActive;

  assign bothReady    = pinSync[PIN_RDY] && pinSync[PIN_XRDY];
  assign strobeActive = strobeWindowFlag && !strobeStopFlag;

  assign handBackPulse = !externalCycleFlag && strobeWindowFlag;

  // pending cleared by release; new request sets it
  always_ff @(posedge busClk) begin
    if (!busRstSync_n) begin
      reqTglSeen_q       <= FLAG_RESET;
      requestPendingFlag <= FLAG_RESET;
    end else begin
      reqTglSeen_q <= reqTglSync;
      if (reqTglSync != reqTglSeen_q) begin
        requestPendingFlag <= 1'b1;
      end else if (handBackPulse) begin
        requestPendingFlag <= 1'b0;
      end
    end
  end

  // Assert follows pending; dropped on a lost arbitration or the release
  always_ff @(posedge busClk) begin
    if (!busRstSync_n) begin
      arbitrationAssertFlag <= FLAG_RESET;
    end else if (handBackPulse) begin
      arbitrationAssertFlag <= 1'b0;
    end else if (requestPendingFlag && !arbitrationAssertFlag &&
                 !pinSync[PIN_HOLDACT] && !pinSync[PIN_HLDA]) begin
      arbitrationAssertFlag <= 1'b1;
    end else if (pinSync[PIN_HLDA] && !pinSync[PIN_WINNER] &&
                 !controlDriveFlag) begin
      arbitrationAssertFlag <= 1'b0;
    end
  end

  always_ff @(posedge busClk) begin
    if (!busRstSync_n) begin
      externalCycleFlag <= FLAG_RESET;
    end else if (strobeStopFlag) begin
      externalCycleFlag <= 1'b0;
    end else if (controlDriveFlag && arbitrationAssertFlag &&
                 !strobeWindowFlag) begin
      externalCycleFlag <= 1'b1;
    end
  end

  // window set after first T-state; cleared once control released
  always_ff @(posedge busClk) begin
    if (!busRstSync_n) begin
      strobeWindowFlag <= FLAG_RESET;
    end else if (externalCycleFlag && !strobeStopFlag) begin
      strobeWindowFlag <= 1'b1;
    end else if (!externalCycleFlag && !controlDriveFlag) begin
      strobeWindowFlag <= 1'b0;
    end
  end

  // ready sampled as the window opens
  // resampled on every wait state edge
  always_ff @(posedge busClk) begin
    if (!busRstSync_n) begin
      readyOk_q <= FLAG_RESET;
    end else if (externalCycleFlag && !strobeStopFlag) begin
      readyOk_q <= bothReady;
    end else begin
      readyOk_q <= 1'b0;
    end
  end

  // stop set; cleared with window low
  always_ff @(posedge busClk) begin
    if (!busRstSync_n) begin
      strobeStopFlag <= FLAG_RESET;
    end else if (strobeActive && readyOk_q) begin
      strobeStopFlag <= 1'b1;
    end else if (!strobeWindowFlag) begin
      strobeStopFlag <= 1'b0;
    end
  end

  // falling window toggles the wait release across
  always_ff @(posedge busClk) begin
    if (!busRstSync_n) begin
      endTgl_q <= FLAG_RESET;
    end else if (strobeWindowFlag && !externalCycleFlag &&
                 !controlDriveFlag) begin
      endTgl_q <= !endTgl_q;
    end
  end

  // Address, status and write data captured when the request arrives;
  // the local side holds them still while the toggle is in flight
  always_ff @(posedge busClk) begin
    if (!busRstSync_n) begin
      busAddr    <= '0;
      busStatus  <= STATUS_IDLE;
      busDataOut <= '0;
    end else if (reqTglSync != reqTglSeen_q) begin
      busAddr    <= {extAddrHigh, req_q.addrLow};
      busStatus  <= '{!req_q.isIo && req_q.isRead,
                      req_q.isIo && req_q.isRead,
                      req_q.isIo && !req_q.isRead,
                      !req_q.isIo && req_q.isFetch,
                      req_q.isRead};
      busDataOut <= req_q.wrData;
    // read data latched at the end of the strobe
    end else if (strobeActive && readyOk_q && req_q.isRead) begin
      busDataOut <= busDataIn;
    end
  end

  // ***************************************************************
  // Bus clock domain, falling edge
  // ***************************************************************
  logic stvalLow_q;

  // control drive set; cleared once assert is gone
  always_ff @(negedge busClk) begin
    if (!busRstSync_n) begin
      controlDriveFlag <= FLAG_RESET;
    end else if (!arbitrationAssertFlag && !externalCycleFlag) begin
      controlDriveFlag <= 1'b0;
    end else if (arbitrationAssertFlag && pinSync[PIN_HLDA] &&
                 pinSync[PIN_WINNER] && !strobeWindowFlag) begin
      controlDriveFlag <= 1'b1;
    end
  end

  // status valid in the second half of sync
  always_ff @(negedge busClk) begin
    if (!busRstSync_n) begin
      stvalLow_q <= FLAG_RESET;
    end else begin
      stvalLow_q <= externalCycleFlag && !strobeWindowFlag;
    end
  end

  // ***************************************************************
  // Pin outputs
  // ***************************************************************
  // sync in the first T-state
  assign pSync    = externalCycleFlag && !strobeWindowFlag;
  assign pStval_n = !(stvalLow_q && pSync);
  assign pDbin    = strobeActive && req_q.isRead;
  assign pWr_n    = !(strobeActive && !req_q.isRead);
  // data path drivers follow the cycle flag, control the drive flag
  // all drivers off while the flags sit at reset
  assign addrStatusDataOe    = externalCycleFlag;
  assign cpuCommandDisable_n = !externalCycleFlag;
  assign controlOe           = controlDriveFlag;
  assign cpuBusDisable_n     = !controlDriveFlag;
  // Open-collector hold request: pull low while asserting
  assign holdOut   = 1'b0;
  assign holdOe    = arbitrationAssertFlag;
  assign arbEnable = arbitrationAssertFlag;

  // ***************************************************************
  // Checks
  // ***************************************************************
  sequence strobeEnds;
    strobeStopFlag && externalCycleFlag ##1 !externalCycleFlag;
  endsequence

  sequence handBack;
    !externalCycleFlag ##[1:2] !strobeWindowFlag ##1 !strobeStopFlag;
  endsequence

  window_set_a: assert property (@(posedge busClk) disable iff (!busRstSync_n)
    $rose(externalCycleFlag) |-> !strobeWindowFlag ##1 strobeWindowFlag)
    else $error("strobe window did not open after first state");
  strobe_dir_a: assert property (@(posedge busClk) disable iff (!busRstSync_n)
    strobeActive |-> (pDbin == req_q.isRead) && (pWr_n == req_q.isRead))
    else $error("strobe direction wrong");
  wait_state_a: assert property (@(posedge busClk) disable iff (!busRstSync_n)
    strobeActive && !readyOk_q |=> !strobeStopFlag)
    else $error("stop set without ready");
  stop_set_a: assert property (@(posedge busClk) disable iff (!busRstSync_n)
    strobeActive && readyOk_q |=> strobeStopFlag && !pDbin && pWr_n)
    else $error("strobe stop not set");
  resample_a: assert property (@(posedge busClk) disable iff (!busRstSync_n)
    strobeActive && !readyOk_q |=> readyOk_q == $past(bothReady))
    else $error("ready not resampled");
  cycle_clear_a: assert property (@(posedge busClk)
    disable iff (!busRstSync_n)
    strobeStopFlag && externalCycleFlag |=> !externalCycleFlag)
    else $error("cycle flag held after stop");
  release_a: assert property (@(posedge busClk) disable iff (!busRstSync_n)
    handBackPulse |=> !requestPendingFlag && !arbitrationAssertFlag)
    else $error("release did not drop pending and assert");
  drivers_a: assert property (@(posedge busClk) disable iff (!busRstSync_n)
    $fell(externalCycleFlag) |-> !addrStatusDataOe && controlOe
      && cpuCommandDisable_n)
    else $error("driver hand-back wrong");
  ctrl_clear_a: assert property (@(negedge busClk)
    disable iff (!busRstSync_n)
    controlDriveFlag && !arbitrationAssertFlag && !externalCycleFlag
      |=> !controlDriveFlag)
    else $error("control drive not released");
  window_clear_a: assert property (@(posedge busClk)
    disable iff (!busRstSync_n)
    strobeWindowFlag && !externalCycleFlag && !controlDriveFlag
      |=> !strobeWindowFlag && (endTgl_q != $past(endTgl_q)))
    else $error("window or wait release wrong");
  hand_back_a: assert property (@(posedge busClk)
    disable iff (!busRstSync_n)
    strobeEnds |-> ##[0:1] handBack)
    else $error("sequencer not idle after cycle");
  read_latch_a: assert property (@(posedge busClk)
    disable iff (!busRstSync_n)
    strobeActive && readyOk_q && req_q.isRead
      |=> busDataOut == $past(busDataIn))
    else $error("read data not latched");
  sync_first_a: assert property (@(posedge busClk)
    disable iff (!busRstSync_n)
    $rose(externalCycleFlag) |-> pSync ##1 !pSync)
    else $error("sync not one state");
  cycle_set_a: assert property (@(posedge busClk)
    disable iff (!busRstSync_n)
    $rose(controlDriveFlag) && arbitrationAssertFlag
      |=> externalCycleFlag)
    else $error("cycle flag not set after control drive");
  reset_idle_a: assert property (@(posedge busClk)
    !busRstSync_n |=> !externalCycleFlag && !strobeWindowFlag
      && !strobeStopFlag && !holdOe)
    else $error("reset left a flag set");
  ready_low_a: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(localReady) && externalAccessDecode
      |-> $past(endTglSync != endTglSeen_q))
    else $error("local ready rose before the bus cycle ended");

endmodule : tmb_bus_cycle

// ===== hdl/tmb_pkg.sv
// Package: types and constants for the temporary-master bus cycle sequencer
package tmb_pkg;

  // ***************************************************************
  // Widths
  // ***************************************************************
  localparam int unsigned ADDR_LOW_W  = 8;
  localparam int unsigned ADDR_HIGH_W = 16;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned SYNC_STAGES = 2;

  // ***************************************************************
  // Reset values and field positions
  // ***************************************************************
  localparam logic        FLAG_RESET       = 1'b0;
  localparam logic [15:0] EXT_MEM_BASE     = 16'hC000;
  localparam int unsigned EXT_MEM_TOP_BITS = 2;        // Address bits 15:14
  localparam int unsigned BUS_PIN_W        = 5;
  localparam int unsigned PIN_RDY          = 0;
  localparam int unsigned PIN_XRDY         = 1;
  localparam int unsigned PIN_HLDA         = 2;
  localparam int unsigned PIN_HOLDACT      = 3;
  localparam int unsigned PIN_WINNER       = 4;

  // ***************************************************************
  // Carried types
  // ***************************************************************
  typedef struct packed {
    logic                  isIo;
    logic                  isRead;
    logic                  isFetch;
    logic [ADDR_LOW_W-1:0] addrLow;
    logic [DATA_W-1:0]     wrData;
  } tmb_req_t;

  typedef struct packed {
    logic sMemRead;
    logic sInput;
    logic sOutput;
    logic sFetch;
    logic sWriteOut_n;
  } tmb_status_t;

  localparam tmb_status_t STATUS_IDLE = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

  // Local-side sequencer, Gray coded along idle -> wait -> done
  typedef enum logic [1:0] {
    LOC_IDLE = 2'b00,
    LOC_WAIT = 2'b01,
    LOC_DONE = 2'b11
  } tmb_loc_state_t;

endpackage : tmb_pkg

// ===== hdl/tmb_sync.sv
// Two-stage synchroniser for a vector of independent levels
`timescale 1ns/1ps
module tmb_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] din,
  output      logic [WIDTH-1:0] dout
);
  import tmb_pkg::*;

  logic [WIDTH-1:0] meta_q;

  // First stage is read only by the second stage
  always_ff @(posedge clk) begin
    meta_q <= din;
    dout   <= meta_q;
  end

endmodule : tmb_sync
